// file: design/dbgl_mem.sv
// Save/restore word store with registered read
`timescale 1ns/1ns
module dbgl_mem #(
   parameter int AW = 4,
   parameter int DW = 32
) (
   input wire logic ref_clk_in,
   dbgl_mem_if.mem port
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];
   logic [DW-1:0] rd_q;

   // Write on strobe, read data registered every cycle
   always_ff @(posedge ref_clk_in) begin
      if (port.we) begin
         mem_q[port.addr] <= port.wdata;
      end
      rd_q <= mem_q[port.addr];
   end

   assign port.rdata = rd_q;
endmodule

// file: design/dbgl_regs.sv
// Debug lock, event catch and cache control register bank on AHB-Lite
// Functional notes
// - Event catch at 0x024, bit 0 read-write reset 0, rest zero.
// - Unlock catch enabled raises halting debug event on unlock.
// - Event only on locked-to-unlocked transition.
// - Without power-down debug, catch enable reads zero.
// - Without power-down debug, lock registers read zero, ignore writes.
// - Write-only lock key register at 0x300 reads zero.
// - Key write sets lock; protected accesses then get error response.
// - Any other value written clears the lock.
// - Key write resets save/restore counter.
// - Lock change may lag until next barrier; software synchronises.
// - Lock status at 0x304, bit 0 says lock implemented.
// - Status bit 1 shows lock; reset takes lock init pin.
// - Status bit 2 always zero.
// - Save/restore port at 0x308 steps counter through state words.
// - Cache controls apply in debug state with abort discard set.
// - Cache control at 0x028, bits 2..0, upper bits zero.
// - Line-fill bits: 0 stops fills and evictions, 1 normal.
// - Fill disabled: hits use cache, misses bypass, no allocation.
// - Maintenance operations unaffected by line-fill bits.
// - Bit 2 low forces write-through in debug state.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
module dbgl_regs #(
   parameter bit PWRDN_SUPPORT = 1'b1,
   parameter int SR_DEPTH = dbgl_pkg::SR_DEPTH_DEF
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [dbgl_pkg::ADDR_W-1:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [dbgl_pkg::DATA_W-1:0] hwdata_in,
   input wire logic hready_in,
   output logic [dbgl_pkg::DATA_W-1:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic lock_init_pin_in,
   input wire logic debug_state_in,
   input wire logic abort_discard_in,
   input wire logic maint_op_in,
   output logic halt_event_out,
   output logic os_lock_out,
   output logic data_linefill_allow_out,
   output logic instr_linefill_allow_out,
   output logic force_write_through_low_out
);
   import dbgl_pkg::*;

   localparam int CNT_W = (SR_DEPTH > 1) ? $clog2(SR_DEPTH) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SR_DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   typedef enum logic [1:0] {
      DBGL_IDLE,
      DBGL_WAIT,
      DBGL_LAST
   } dbgl_bus_st_t;

   // Bus phase state
   dbgl_bus_st_t st_q, st_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic write_q, write_d;
   logic word_q, word_d;
   logic rdy_q, rdy_d;
   logic resp_q, resp_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic accept;
   logic prot_hit;

   // Register state
   logic ecr_q, ecr_d;
   logic [CC_W-1:0] cc_q, cc_d;
   logic lock_q, lock_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic halt_q, halt_d;
   logic dfill_q, dfill_d;
   logic ifill_q, ifill_d;
   logic wt_q, wt_d;
   logic lock_init_s;
   logic wr_ok;
   logic access;
   logic apply;
   logic [DATA_W-1:0] rd_mux;

   dbgl_mem_if #(.AW(CNT_W), .DW(DATA_W)) mem_bus ();

   // Lock init pin crosses in through three stages
   dbgl_sync u_sync (
      .ref_clk_in(ref_clk_in),
      .d_in(lock_init_pin_in),
      .q_out(lock_init_s)
   );

   // Save/restore state words
   dbgl_mem #(.AW(CNT_W), .DW(DATA_W)) u_mem (
      .ref_clk_in(ref_clk_in),
      .port(mem_bus.mem)
   );

   // Address decode for a new transfer
   always_comb begin
      accept = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in;
      prot_hit = (haddr_in == OFF_EVENT_CATCH) || (haddr_in == OFF_CACHE_CTRL);
   end

   // Bus sequencer: one wait state, error takes two cycles
   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      write_d = write_q;
      word_d = word_q;
      rdy_d = rdy_q;
      resp_d = resp_q;
      case (st_q)
         DBGL_WAIT: begin
            st_d = DBGL_LAST;
            rdy_d = 1'b1;
         end
         DBGL_IDLE, DBGL_LAST: begin
            st_d = DBGL_IDLE;
            rdy_d = 1'b1;
            resp_d = HRESP_OKAY;
            if (accept) begin
               st_d = DBGL_WAIT;
               rdy_d = 1'b0;
               addr_d = haddr_in;
               write_d = hwrite_in;
               word_d = (hsize_in == HSIZE_WORD);
               // Locked registers answer with error
               resp_d = (prot_hit && lock_q) ? HRESP_ERROR : HRESP_OKAY;
            end
         end
         default: begin
            st_d = DBGL_IDLE;
            rdy_d = 1'b1;
            resp_d = HRESP_OKAY;
         end
      endcase
   end

   // Read value of the addressed register
   always_comb begin
      rd_mux = '0;
      case (addr_q)
         OFF_EVENT_CATCH: rd_mux[EC_UNLOCK_BIT] = ecr_q;
         OFF_CACHE_CTRL: rd_mux[CC_W-1:0] = cc_q;
         OFF_LOCK_STATE: begin
            // Whole register zero when lock absent
            rd_mux[LS_IMPL_BIT] = PWRDN_SUPPORT;
            rd_mux[LS_LOCKED_BIT] = lock_q;
            rd_mux[LS_ACC32_BIT] = 1'b0;
         end
         OFF_SAVE_RESTORE: rd_mux = PWRDN_SUPPORT ? mem_bus.rdata : '0;
         default: rd_mux = '0;
      endcase
   end

   // Register updates in the first data-phase cycle; lock acts at once
   always_comb begin
      access = (st_q == DBGL_WAIT) && (resp_q == HRESP_OKAY);
      wr_ok = access && write_q && word_q;
      ecr_d = ecr_q;
      cc_d = cc_q;
      lock_d = lock_q;
      cnt_d = cnt_q;
      rdata_d = rdata_q;
      mem_bus.we = 1'b0;
      mem_bus.addr = cnt_q;
      mem_bus.wdata = hwdata_in;
      if (access && !write_q) begin
         rdata_d = rd_mux;
      end else if (access) begin
         rdata_d = '0;
      end else if (st_q == DBGL_WAIT) begin
         rdata_d = '0;
      end
      if (wr_ok && addr_q == OFF_EVENT_CATCH) begin
         ecr_d = PWRDN_SUPPORT && hwdata_in[EC_UNLOCK_BIT];
      end
      if (wr_ok && addr_q == OFF_CACHE_CTRL) begin
         cc_d = hwdata_in[CC_W-1:0];
      end
      if (wr_ok && addr_q == OFF_LOCK_KEY && PWRDN_SUPPORT) begin
         if (hwdata_in == LOCK_KEY) begin
            lock_d = 1'b1;
            cnt_d = '0;
         end else begin
            lock_d = 1'b0;
         end
      end
      if (access && addr_q == OFF_SAVE_RESTORE && PWRDN_SUPPORT) begin
         // Each access steps the sequence once
         cnt_d = (cnt_q == CNT_LAST) ? '0 : cnt_q + CNT_ONE;
         mem_bus.we = write_q && word_q;
      end
   end

   // Unlock catch and cache behaviour outputs
   always_comb begin
      halt_d = ecr_q && lock_q && !lock_d;
      // Controls bite only for debugger ops with aborts discarded
      apply = debug_state_in && abort_discard_in;
      // Maintenance keeps its normal line-fill behaviour
      dfill_d = !apply || maint_op_in || cc_q[CC_DATA_BIT];
      ifill_d = !apply || maint_op_in || cc_q[CC_INSTR_BIT];
      wt_d = !apply || cc_q[CC_WT_BIT];
   end

   // Registers with synchronous reset
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         st_q <= DBGL_IDLE;
         addr_q <= '0;
         write_q <= 1'b0;
         word_q <= 1'b0;
         rdy_q <= 1'b1;
         resp_q <= HRESP_OKAY;
         rdata_q <= '0;
         ecr_q <= EC_RESET;
         cc_q <= CC_RESET;
         lock_q <= PWRDN_SUPPORT && lock_init_s;
         cnt_q <= '0;
         halt_q <= 1'b0;
         dfill_q <= 1'b1;
         ifill_q <= 1'b1;
         wt_q <= 1'b1;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         write_q <= write_d;
         word_q <= word_d;
         rdy_q <= rdy_d;
         resp_q <= resp_d;
         rdata_q <= rdata_d;
         ecr_q <= ecr_d;
         cc_q <= cc_d;
         lock_q <= lock_d;
         cnt_q <= cnt_d;
         halt_q <= halt_d;
         dfill_q <= dfill_d;
         ifill_q <= ifill_d;
         wt_q <= wt_d;
      end
   end

   // Outputs straight from flip-flops
   assign hrdata_out = rdata_q;
   assign hreadyout_out = rdy_q;
   assign hresp_out = resp_q;
   assign halt_event_out = halt_q;
   assign os_lock_out = lock_q;
   assign data_linefill_allow_out = dfill_q;
   assign instr_linefill_allow_out = ifill_q;
   assign force_write_through_low_out = wt_q;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   // Steps of a transfer
   sequence key_write_s;
      (st_q == DBGL_WAIT) && access && write_q && word_q && (addr_q == OFF_LOCK_KEY);
   endsequence

   sequence err_tail_s;
      !rdy_q && resp_q ##1 rdy_q && resp_q;
   endsequence

   // Key sets lock and rewinds counter
   key_lock_a: assert property (key_write_s and (hwdata_in == LOCK_KEY)
      |=> lock_q == PWRDN_SUPPORT && cnt_q == '0)
      else $error("key write did not lock");

   // Other value unlocks
   key_unlock_a: assert property (key_write_s and (hwdata_in != LOCK_KEY) |=> !lock_q)
      else $error("non-key write did not unlock");

   // Locked protected access gets two-cycle error
   lock_error_a: assert property (accept && prot_hit && lock_q && st_q != DBGL_WAIT
      |=> err_tail_s)
      else $error("protected access while locked not refused");

   // Catch pulse only on falling lock with enable
   unlock_catch_a: assert property (halt_q |->
      $past(lock_q) && !lock_q && $past(ecr_q))
      else $error("unlock catch without unlock");

   // Enabled catch fires on unlock
   catch_fire_a: assert property (ecr_q && $fell(lock_q) |-> halt_q)
      else $error("unlock catch missed");

   // Event catch read value
   ecr_read_a: assert property ((st_q == DBGL_LAST) && !write_q && !resp_q
      && (addr_q == OFF_EVENT_CATCH) |-> rdata_q == {31'h0, ecr_q})
      else $error("event catch read wrong");

   // Lock status read value
   lock_status_a: assert property ((st_q == DBGL_LAST) && !write_q
      && (addr_q == OFF_LOCK_STATE) |-> rdata_q[DATA_W-1:LS_ACC32_BIT] == '0
      && rdata_q[LS_LOCKED_BIT] == lock_q && rdata_q[LS_IMPL_BIT] == PWRDN_SUPPORT)
      else $error("lock status read wrong");

   // Counter steps by one per port access
   cnt_step_a: assert property (access && (addr_q == OFF_SAVE_RESTORE) && PWRDN_SUPPORT
      |=> cnt_q == (($past(cnt_q) == CNT_LAST) ? '0 : $past(cnt_q) + CNT_ONE))
      else $error("save/restore counter misstep");

   // Data fill follows control bit in debug state
   data_fill_a: assert property (apply && !maint_op_in
      |=> dfill_q == $past(cc_q[CC_DATA_BIT]))
      else $error("data line-fill output wrong");

   // Write-through forced when bit low
   write_thru_a: assert property (apply && !cc_q[CC_WT_BIT] |=> !wt_q)
      else $error("write-through not forced");

   // Unsupported build never locks
   no_lock_a: assert property (!PWRDN_SUPPORT |-> !lock_q && !ecr_q)
      else $error("lock present without support");

   // Instruction fill follows control bit in debug state
   instr_fill_a: assert property (apply && !maint_op_in
      |=> ifill_q == $past(cc_q[CC_INSTR_BIT]))
      else $error("instruction line-fill output wrong");

   // Maintenance keeps both fills allowed
   maint_fill_a: assert property (apply && maint_op_in |=> dfill_q && ifill_q)
      else $error("maintenance affected by line-fill bits");

   // Controls stay normal unless debug state with aborts discarded
   no_apply_a: assert property (!apply |=> dfill_q && ifill_q && wt_q)
      else $error("cache controls applied outside debug state");

   // Key register reads zero
   key_read_a: assert property ((st_q == DBGL_LAST) && !write_q
      && (addr_q == OFF_LOCK_KEY) |-> rdata_q == '0)
      else $error("lock key register read not zero");

   // Refused access leaves protected registers alone
   prot_ignore_a: assert property ((st_q == DBGL_WAIT) && resp_q
      |=> $stable(ecr_q) && $stable(cc_q))
      else $error("protected register changed while locked");
endmodule

// file: design/dbgl_sync.sv
// Three-stage synchroniser for a level from a pin
`timescale 1ns/1ns
module dbgl_sync (
   input wire logic ref_clk_in,
   input wire logic d_in,
   output logic q_out
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic st_q;
   logic st_d;

   // Shift in; accept a change once stages two and three agree
   always_comb begin
      sh_d = {sh_q[1:0], d_in};
      st_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : st_q;
   end

   // Data stages, no reset needed
   always_ff @(posedge ref_clk_in) begin
      sh_q <= sh_d;
      st_q <= st_d;
   end

   assign q_out = st_q;
endmodule

// file: inc/dbgl_mem_if.sv
// Port between the register bank and the save/restore store
`timescale 1ns/1ns
interface dbgl_mem_if #(parameter int AW = 4, parameter int DW = 32);
   logic we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output we, addr, wdata, input rdata);
   modport mem (input we, addr, wdata, output rdata);
endinterface

// file: inc/dbgl_pkg.sv
// Constants shared by the debug lock and cache control register bank
package dbgl_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_EVENT_CATCH = 12'h024;
   localparam logic [ADDR_W-1:0] OFF_CACHE_CTRL = 12'h028;
   localparam logic [ADDR_W-1:0] OFF_LOCK_KEY = 12'h300;
   localparam logic [ADDR_W-1:0] OFF_LOCK_STATE = 12'h304;
   localparam logic [ADDR_W-1:0] OFF_SAVE_RESTORE = 12'h308;
   // Lock key
   localparam logic [DATA_W-1:0] LOCK_KEY = 32'hc5acce55;
   // Lock status field positions
   localparam int LS_IMPL_BIT = 0;
   localparam int LS_LOCKED_BIT = 1;
   localparam int LS_ACC32_BIT = 2;
   // Cache control field positions and reset value
   localparam int CC_DATA_BIT = 0;
   localparam int CC_INSTR_BIT = 1;
   localparam int CC_WT_BIT = 2;
   localparam int CC_W = 3;
   localparam logic [CC_W-1:0] CC_RESET = 3'h7;
   // Event catch field
   localparam int EC_UNLOCK_BIT = 0;
   localparam logic EC_RESET = 1'h0;
   // Bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic HRESP_ERROR = 1'h1;
   localparam int HTRANS_ACTIVE_BIT = 1;
   // Save/restore store depth
   localparam int SR_DEPTH_DEF = 16;
endpackage

// file: tb/dbgl_dbg_model.sv
// Debugger-side bus master model issuing single word transfers
`timescale 1ns/1ns
module dbgl_dbg_model (
   input wire logic ref_clk_in,
   input wire logic hready_in,
   input wire logic [dbgl_pkg::DATA_W-1:0] hrdata_in,
   input wire logic hresp_in,
   output logic hsel_out,
   output logic [dbgl_pkg::ADDR_W-1:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [dbgl_pkg::DATA_W-1:0] hwdata_out
);
   import dbgl_pkg::*;

   // Idle bus at time zero
   initial begin
      hsel_out = 1'b0;
      haddr_out = '0;
      htrans_out = 2'b00;
      hwrite_out = 1'b0;
      hsize_out = HSIZE_WORD;
      hwdata_out = '0;
   end

   // One whole-word transfer; entered just after a rising edge
   // Lock state is relied on only once the transfer has completed
   // Vector catch and debug enables live outside this bank; never set here
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] rd, output logic resp);
      hsel_out <= 1'b1;
      htrans_out <= 2'b10;
      haddr_out <= a;
      hwrite_out <= wr;
      hsize_out <= HSIZE_WORD;
      do @(posedge ref_clk_in); while (hready_in !== 1'b1);
      htrans_out <= 2'b00;
      hwdata_out <= wr ? wd : ~hwdata_out;
      do @(posedge ref_clk_in); while (hready_in !== 1'b1);
      rd = hrdata_in;
      resp = hresp_in;
   endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the debug lock and cache control register bank
`timescale 1ns/1ns
module tb;
   import dbgl_pkg::*;
   logic ref_clk_in, resetn_in, lock_init, dbg_st, ab_dis, maint;
   logic hsel, hwrite, hready, hresp, hresp_np, halt, lock, lock_np, fill_d, fill_i, wt_low;
   logic [ADDR_W-1:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [DATA_W-1:0] hwdata, hrdata, hrdata_np;
   logic [2:0] cmb [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
   logic [2:0] cexp [4] = '{3'b111, 3'b111, 3'b010, 3'b011};
   int failures, checked, halt_cnt;

   dbgl_regs uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .lock_init_pin_in(lock_init),
      .debug_state_in(dbg_st), .abort_discard_in(ab_dis), .maint_op_in(maint), .halt_event_out(halt),
      .os_lock_out(lock), .data_linefill_allow_out(fill_d), .instr_linefill_allow_out(fill_i),
      .force_write_through_low_out(wt_low));
   dbgl_regs #(.PWRDN_SUPPORT(1'b0)) uut_np (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata_np), .hreadyout_out(), .hresp_out(hresp_np),
      .lock_init_pin_in(lock_init), .debug_state_in(dbg_st), .abort_discard_in(ab_dis), .maint_op_in(maint),
      .halt_event_out(), .os_lock_out(lock_np), .data_linefill_allow_out(), .instr_linefill_allow_out(),
      .force_write_through_low_out());
   dbgl_dbg_model dbg (.ref_clk_in(ref_clk_in), .hready_in(hready), .hrdata_in(hrdata), .hresp_in(hresp),
      .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata));

   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // Halt event pulse counter
   always @(posedge ref_clk_in) begin
      if (halt === 1'b1) halt_cnt++;
   end

   task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic exp_r);
      logic [DATA_W-1:0] d;
      logic r;
      dbg.xfer(1'b0, a, '0, d, r);
      chk($sformatf("read data %h", a), exp, d);
      chk($sformatf("read response %h", a), {31'h0, exp_r}, {31'h0, r});
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd, input logic exp_r);
      logic [DATA_W-1:0] d;
      logic r;
      dbg.xfer(1'b1, a, wd, d, r);
      chk($sformatf("write response %h", a), {31'h0, exp_r}, {31'h0, r});
   endtask

   // Mid-run reset with the lock strap at a given level
   task automatic reset_with(input logic strap);
      lock_init <= strap;
      resetn_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      @(posedge ref_clk_in);
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog against a hung transfer
   initial begin
      #100000;
      failures++;
      $display("[FAIL] watchdog expected completion seen timeout");
      give_verdict();
   end

   // Main sequence
   initial begin
      resetn_in = 1'b0;
      lock_init = 1'b1;
      dbg_st = 1'b0;
      ab_dis = 1'b0;
      maint = 1'b0;
      failures = 0;
      checked = 0;
      halt_cnt = 0;
      repeat (8) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      @(posedge ref_clk_in);
      chk("lock after reset", 32'h1, {31'h0, lock});
      chk("cache outputs", 32'h7, {29'h0, wt_low, fill_i, fill_d});
      rd(OFF_LOCK_STATE, 32'h3, HRESP_OKAY);
      chk("status without power-down", 32'h0, hrdata_np);
      rd(OFF_EVENT_CATCH, 32'h0, HRESP_ERROR);
      chk("response without power-down", 32'h0, {31'h0, hresp_np});
      wr(OFF_CACHE_CTRL, 32'h0, HRESP_ERROR);
      wr(OFF_LOCK_KEY, 32'h0, HRESP_OKAY);
      chk("lock after other value", 32'h0, {31'h0, lock});
      rd(OFF_CACHE_CTRL, 32'h7, HRESP_OKAY);
      rd(OFF_LOCK_KEY, 32'h0, HRESP_OKAY);
      rd(OFF_LOCK_STATE, 32'h1, HRESP_OKAY);
      rd(12'h100, 32'h0, HRESP_OKAY);
      wr(OFF_EVENT_CATCH, 32'hffffffff, HRESP_OKAY);
      rd(OFF_EVENT_CATCH, 32'h1, HRESP_OKAY);
      chk("catch without power-down", 32'h0, hrdata_np);
      wr(OFF_LOCK_KEY, LOCK_KEY, HRESP_OKAY);
      chk("lock after key", 32'h1, {31'h0, lock});
      chk("lock without power-down", 32'h0, {31'h0, lock_np});
      wr(OFF_LOCK_KEY, 32'h1, HRESP_OKAY);
      @(posedge ref_clk_in);
      chk("unlock events", 32'h1, halt_cnt);
      wr(OFF_LOCK_KEY, 32'h2, HRESP_OKAY);
      @(posedge ref_clk_in);
      chk("unlock events", 32'h1, halt_cnt);
      // Save/restore: lock, store three words, rewind by key, read back
      wr(OFF_LOCK_KEY, LOCK_KEY, HRESP_OKAY);
      for (int i = 0; i < 3; i++) wr(OFF_SAVE_RESTORE, 32'ha5a50000 + i, HRESP_OKAY);
      wr(OFF_LOCK_KEY, LOCK_KEY, HRESP_OKAY);
      for (int i = 0; i < 3; i++) rd(OFF_SAVE_RESTORE, 32'ha5a50000 + i, HRESP_OKAY);
      wr(OFF_LOCK_KEY, 32'h0, HRESP_OKAY);
      @(posedge ref_clk_in);
      chk("unlock events", 32'h2, halt_cnt);
      // Cache control readback and effect on outputs
      wr(OFF_CACHE_CTRL, 32'hffffffff, HRESP_OKAY);
      rd(OFF_CACHE_CTRL, 32'h7, HRESP_OKAY);
      wr(OFF_CACHE_CTRL, 32'h2, HRESP_OKAY);
      rd(OFF_CACHE_CTRL, 32'h2, HRESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         {dbg_st, ab_dis, maint} <= cmb[i];
         repeat (3) @(posedge ref_clk_in);
         chk("cache outputs", {29'h0, cexp[i]}, {29'h0, wt_low, fill_i, fill_d});
      end
      // Second reset with the strap low; counter stood at three before it
      reset_with(1'b0);
      chk("lock after reset", 32'h0, {31'h0, lock});
      rd(OFF_EVENT_CATCH, 32'h0, HRESP_OKAY);
      // Third reset with the strap high, so the port is used locked without a key write
      reset_with(1'b1);
      chk("lock after reset", 32'h1, {31'h0, lock});
      rd(OFF_SAVE_RESTORE, 32'ha5a50000, HRESP_OKAY);
      chk("port without power-down", 32'h0, hrdata_np);
      give_verdict();
   end
endmodule
